// >>> hdl/dcs_pkg.sv
// package for the dma channel status and addressing block
// assumes one system clock and a synchronous active-high reset
package dcs_pkg;
    // register byte offsets on the avalon slave
    localparam logic [4:0] DCS_OFS_INT = 5'h00;
    localparam logic [4:0] DCS_OFS_SSA = 5'h04;
    localparam logic [4:0] DCS_OFS_DSA = 5'h08;
    localparam logic [4:0] DCS_OFS_SSIZ = 5'h0C;
    localparam logic [4:0] DCS_OFS_CTL = 5'h10;
    localparam logic [4:0] DCS_OFS_DCSIZ = 5'h14;
    localparam logic [4:0] DCS_OFS_PTR = 5'h18;

    // event flag bit positions, enables sit DCS_IEN_POS higher
    localparam int DCS_F_AERR = 0;
    localparam int DCS_F_ABORT = 1;
    localparam int DCS_F_CELL = 2;
    localparam int DCS_F_BLOCK = 3;
    localparam int DCS_F_HALF = 4;
    localparam int DCS_NFLAG = 5;
    localparam int DCS_IEN_POS = 16;

    // control register fields
    localparam int DCS_C_ON = 0;
    localparam int DCS_C_FORCE = 1;
    localparam int DCS_C_ABORT_IRQ_EN = 3;
    localparam int DCS_C_PAT_ABORT_EN = 5;
    localparam int DCS_C_BUSY = 15;
    localparam int DCS_C_SEL = 16;

    // reset values and the 64 KiB size that a zero size field stands for
    localparam logic [7:0] DCS_AIRQ_SEL_RST = 8'hFF;
    localparam logic [31:0] DCS_ADDR_RST = 32'h0000_0000;
    localparam logic [16:0] DCS_SIZE_MAX = 17'h1_0000;

    typedef enum logic [1:0] {DCS_IDLE, DCS_READ, DCS_WRITE} dcs_fsm_t;

    // one request on the byte memory bus
    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [7:0] wdata;
    } dcs_mem_t;

    typedef struct packed {
        dcs_fsm_t fsm;
        logic [DCS_NFLAG-1:0] flag;
        logic [DCS_NFLAG-1:0] ien;
        logic [31:0] ssa;
        logic [31:0] dsa;
        logic [15:0] ssize;
        logic [15:0] dsize;
        logic [15:0] csize;
        logic on;
        logic airq_en;
        logic pat_en;
        logic [7:0] airq_sel;
        logic [15:0] sptr;
        logic [15:0] dptr;
        logic [16:0] bcnt;
        logic [16:0] ccnt;
        dcs_mem_t mem;
        logic ack;
        logic [31:0] rdata;
    } dcs_state_t;
endpackage

// >>> hdl/dcs_channel.sv
// one dma channel: event flags, start addresses, sizes and byte mover
// assumes memory bus, irq and pattern inputs share CLK_SYS
module dcs_channel (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // avalon-mm register slave
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // byte memory master
    output dcs_pkg::dcs_mem_t MEM,
    input wire logic MEM_ACK,
    input wire logic MEM_ERR,
    input wire logic [7:0] MEM_RDATA,
    // system events
    input wire logic IRQ_VALID,
    input wire logic [7:0] IRQ_NUM,
    input wire logic PAT_MATCH,
    // channel interrupt
    output logic IRQ
);
    dcs_pkg::dcs_state_t st;
    dcs_pkg::dcs_state_t nx;
    localparam int DCS_NFLAG_W = dcs_pkg::DCS_NFLAG;
    logic [DCS_NFLAG_W-1:0] set;
    logic req;
    logic wr;
    logic abort;
    logic [16:0] ss_eff;
    logic [16:0] ds_eff;
    logic [16:0] cs_eff;
    logic [16:0] blk_end;
    logic [16:0] s1;
    logic [16:0] d1;
    logic [16:0] b1;
    logic [16:0] c1;
    logic [31:0] m;
    logic [31:0] rb;
    logic [31:0] ctl_rb;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    // zero in a size field stands for the full 64 KiB
    assign ss_eff = (st.ssize == 16'h0000) ? dcs_pkg::DCS_SIZE_MAX
                                           : {1'b0, st.ssize};
    assign ds_eff = (st.dsize == 16'h0000) ? dcs_pkg::DCS_SIZE_MAX
                                           : {1'b0, st.dsize};
    assign cs_eff = (st.csize == 16'h0000) ? dcs_pkg::DCS_SIZE_MAX
                                           : {1'b0, st.csize};
    assign blk_end = (ss_eff > ds_eff) ? ss_eff : ds_eff;
    assign s1 = {1'b0, st.sptr} + 17'h0_0001;
    assign d1 = {1'b0, st.dptr} + 17'h0_0001;
    assign b1 = st.bcnt + 17'h0_0001;
    assign c1 = st.ccnt + 17'h0_0001;

    assign req = AVS_READ || AVS_WRITE;
    assign AVS_WAITREQUEST = req && !st.ack;
    assign wr = AVS_WRITE && st.ack;
    assign AVS_READDATA = st.rdata;
    assign MEM = st.mem;
    assign IRQ = |(st.flag & st.ien);

    always_comb begin
        ctl_rb = 32'h0000_0000;
        ctl_rb[dcs_pkg::DCS_C_ON] = st.on;
        ctl_rb[dcs_pkg::DCS_C_ABORT_IRQ_EN] = st.airq_en;
        ctl_rb[dcs_pkg::DCS_C_PAT_ABORT_EN] = st.pat_en;
        ctl_rb[dcs_pkg::DCS_C_BUSY] = (st.fsm != dcs_pkg::DCS_IDLE);
        ctl_rb[dcs_pkg::DCS_C_SEL +: 8] = st.airq_sel;
        rb = 32'h0000_0000;
        unique case (AVS_ADDRESS)
            dcs_pkg::DCS_OFS_INT: begin
                rb[DCS_NFLAG_W-1:0] = st.flag;
                rb[dcs_pkg::DCS_IEN_POS +: DCS_NFLAG_W] = st.ien;
            end
            dcs_pkg::DCS_OFS_SSA: rb = st.ssa;
            dcs_pkg::DCS_OFS_DSA: rb = st.dsa;
            dcs_pkg::DCS_OFS_SSIZ: rb = {16'h0000, st.ssize};
            dcs_pkg::DCS_OFS_CTL: rb = ctl_rb;
            dcs_pkg::DCS_OFS_DCSIZ: rb = {st.csize, st.dsize};
            dcs_pkg::DCS_OFS_PTR: rb = {st.sptr, st.dptr};
            default: rb = 32'h0000_0000;
        endcase
    end

    always_comb begin
        nx = st;
        set = '0;
        abort = 1'b0;
        m = merge(rb, AVS_WRITEDATA, AVS_BYTEENABLE);
        nx.ack = req && !st.ack;
        if (req && !st.ack) begin
            nx.rdata = AVS_READ ? rb : 32'h0000_0000;
        end

        // register writes, taken in the cycle waitrequest is low
        if (wr) begin
            unique case (AVS_ADDRESS)
                dcs_pkg::DCS_OFS_INT: begin
                    nx.ien = m[dcs_pkg::DCS_IEN_POS +: DCS_NFLAG_W];
                    if (AVS_BYTEENABLE[0]) begin
                        // a zero written clears, a one keeps
                        nx.flag = st.flag
                                  & AVS_WRITEDATA[DCS_NFLAG_W-1:0];
                    end
                end
                dcs_pkg::DCS_OFS_SSA: nx.ssa = m;
                dcs_pkg::DCS_OFS_DSA: nx.dsa = m;
                dcs_pkg::DCS_OFS_SSIZ: nx.ssize = m[15:0];
                dcs_pkg::DCS_OFS_CTL: begin
                    nx.on = m[dcs_pkg::DCS_C_ON];
                    nx.airq_en = m[dcs_pkg::DCS_C_ABORT_IRQ_EN];
                    nx.pat_en = m[dcs_pkg::DCS_C_PAT_ABORT_EN];
                    nx.airq_sel = m[dcs_pkg::DCS_C_SEL +: 8];
                end
                dcs_pkg::DCS_OFS_DCSIZ: begin
                    nx.dsize = m[15:0];
                    nx.csize = m[31:16];
                end
                default: begin
                end
            endcase
        end

        // byte mover: read one source byte, write it to the destination
        unique case (st.fsm)
            dcs_pkg::DCS_IDLE: begin
                if (wr && AVS_ADDRESS == dcs_pkg::DCS_OFS_CTL
                    && AVS_BYTEENABLE[0]
                    && AVS_WRITEDATA[dcs_pkg::DCS_C_FORCE] && nx.on) begin
                    nx.fsm = dcs_pkg::DCS_READ;
                    nx.ccnt = 17'h0_0000;
                    nx.mem.req = 1'b1;
                    nx.mem.we = 1'b0;
                    nx.mem.addr = st.ssa + {16'h0000, st.sptr};
                end
            end
            dcs_pkg::DCS_READ: begin
                if (MEM_ACK && !MEM_ERR) begin
                    nx.fsm = dcs_pkg::DCS_WRITE;
                    nx.mem.we = 1'b1;
                    nx.mem.addr = st.dsa + {16'h0000, st.dptr};
                    nx.mem.wdata = MEM_RDATA;
                end
            end
            dcs_pkg::DCS_WRITE: begin
                if (MEM_ACK && !MEM_ERR) begin
                    nx.sptr = (s1 == ss_eff) ? 16'h0000 : s1[15:0];
                    nx.dptr = (d1 == ds_eff) ? 16'h0000 : d1[15:0];
                    nx.bcnt = b1;
                    nx.ccnt = c1;
                    if (d1 == (ds_eff >> 1)) begin
                        set[dcs_pkg::DCS_F_HALF] = 1'b1;
                    end
                    nx.mem.req = 1'b0;
                    nx.fsm = dcs_pkg::DCS_IDLE;
                    if (b1 == blk_end) begin
                        // block finished: channel stops and rewinds
                        set[dcs_pkg::DCS_F_BLOCK] = 1'b1;
                        // the last byte may also close a cell
                        if (c1 == cs_eff) begin
                            set[dcs_pkg::DCS_F_CELL] = 1'b1;
                        end
                        nx.on = 1'b0;
                        nx.sptr = 16'h0000;
                        nx.dptr = 16'h0000;
                        nx.bcnt = 17'h0_0000;
                    end else if (c1 == cs_eff) begin
                        set[dcs_pkg::DCS_F_CELL] = 1'b1;
                    end else if (nx.on) begin
                        nx.fsm = dcs_pkg::DCS_READ;
                        nx.mem.req = 1'b1;
                        nx.mem.we = 1'b0;
                        nx.mem.addr = st.ssa + {16'h0000, nx.sptr};
                    end
                end
            end
        endcase

        // error response on either source or destination access
        if (st.mem.req && MEM_ERR) begin
            set[dcs_pkg::DCS_F_AERR] = 1'b1;
            abort = 1'b1;
        end
        if (IRQ_VALID && st.airq_en && IRQ_NUM == st.airq_sel) begin
            set[dcs_pkg::DCS_F_ABORT] = 1'b1;
            abort = 1'b1;
        end
        if (PAT_MATCH && st.fsm != dcs_pkg::DCS_IDLE) begin
            set[dcs_pkg::DCS_F_BLOCK] = 1'b1;
            if (st.pat_en) begin
                abort = 1'b1;
            end
        end
        if (abort) begin
            // drop any bus request and rewind the channel
            nx.fsm = dcs_pkg::DCS_IDLE;
            nx.mem.req = 1'b0;
            nx.on = 1'b0;
            nx.sptr = 16'h0000;
            nx.dptr = 16'h0000;
            nx.bcnt = 17'h0_0000;
            nx.ccnt = 17'h0_0000;
        end
        // a hardware set beats a software clear in the same cycle
        nx.flag = nx.flag | set;
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st <= '0;
            st.ssa <= dcs_pkg::DCS_ADDR_RST;
            st.dsa <= dcs_pkg::DCS_ADDR_RST;
            st.airq_sel <= dcs_pkg::DCS_AIRQ_SEL_RST;
        end else begin
            st <= nx;
        end
    end

    // checks
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    logic wr_int;
    assign wr_int = wr && AVS_ADDRESS == dcs_pkg::DCS_OFS_INT;

    a_half_full_set:
    assert property (st.fsm == dcs_pkg::DCS_WRITE && MEM_ACK && !MEM_ERR
                     && d1 == (ds_eff >> 1)
                     |=> st.flag[dcs_pkg::DCS_F_HALF])
    else $error("half-full flag not set at destination midpoint");

    a_block_done_stop:
    assert property (st.fsm == dcs_pkg::DCS_WRITE && MEM_ACK && !MEM_ERR
                     && b1 == blk_end
                     |=> st.flag[dcs_pkg::DCS_F_BLOCK] && !st.on
                         && st.fsm == dcs_pkg::DCS_IDLE && st.bcnt == 0)
    else $error("block end did not flag and stop the channel");

    a_cell_done_idle:
    assert property (st.fsm == dcs_pkg::DCS_WRITE && MEM_ACK && !MEM_ERR
                     && b1 != blk_end && c1 == cs_eff && !IRQ_VALID
                     && !PAT_MATCH
                     |=> st.flag[dcs_pkg::DCS_F_CELL]
                         && st.fsm == dcs_pkg::DCS_IDLE && !MEM.req)
    else $error("cell end did not flag and pause");

    a_cell_at_block:
    assert property (st.fsm == dcs_pkg::DCS_WRITE && MEM_ACK && !MEM_ERR
                     && b1 == blk_end && c1 == cs_eff
                     |=> st.flag[dcs_pkg::DCS_F_CELL])
    else $error("cell end at block end not flagged");

    a_abort_irq_hit:
    assert property (IRQ_VALID && st.airq_en && IRQ_NUM == st.airq_sel
                     |=> st.flag[dcs_pkg::DCS_F_ABORT] && !MEM.req
                         && st.fsm == dcs_pkg::DCS_IDLE)
    else $error("matching abort interrupt did not abort");

    a_abort_irq_off:
    assert property (!st.airq_en && !st.flag[dcs_pkg::DCS_F_ABORT]
                     |=> !st.flag[dcs_pkg::DCS_F_ABORT])
    else $error("abort flag set while abort interrupt disabled");

    a_addr_error_stop:
    assert property (MEM.req && MEM_ERR
                     |=> st.flag[dcs_pkg::DCS_F_AERR] && !MEM.req ##1 !MEM.req)
    else $error("address error did not flag and stop");

    a_addr_reset_zero:
    assert property ($past(RST) |-> st.ssa == 32'h0000_0000
                     && st.dsa == 32'h0000_0000 && st.ssize == 16'h0000)
    else $error("start address or size not zero after reset");

    a_src_addr_write:
    assert property (wr && AVS_ADDRESS == dcs_pkg::DCS_OFS_SSA
                     && AVS_BYTEENABLE == 4'hF
                     |=> st.ssa == $past(AVS_WRITEDATA))
    else $error("source start address write did not land");

    a_dst_addr_write:
    assert property (wr && AVS_ADDRESS == dcs_pkg::DCS_OFS_DSA
                     && AVS_BYTEENABLE == 4'hF
                     |=> st.dsa == $past(AVS_WRITEDATA))
    else $error("destination start address write did not land");

    a_size_zero_full:
    assert property (st.ssize == 16'h0000 |-> ss_eff == 17'h1_0000)
    else $error("zero source size not treated as 65536");

    a_size_upper_zero:
    assert property (AVS_READ && !AVS_WAITREQUEST
                     && $past(AVS_ADDRESS) == dcs_pkg::DCS_OFS_SSIZ
                     |-> AVS_READDATA[31:16] == 16'h0000)
    else $error("source size upper half reads nonzero");

    a_irq_needs_enable:
    assert property (st.flag != 0 && st.ien == 0 |-> !IRQ)
    else $error("interrupt raised without enable");

    a_pattern_abort:
    assert property (PAT_MATCH && st.pat_en && st.fsm != dcs_pkg::DCS_IDLE
                     |=> !st.on && st.flag[dcs_pkg::DCS_F_BLOCK] ##1 !MEM.req)
    else $error("pattern abort left channel running");

    a_flags_sticky:
    assert property (!wr_int |=> (st.flag & $past(st.flag)) == $past(st.flag))
    else $error("event flag lost without a software clear");

    c_block_done: cover property (st.fsm == dcs_pkg::DCS_WRITE && MEM_ACK
                                  && b1 == blk_end);
    c_cell_done: cover property ($rose(st.flag[dcs_pkg::DCS_F_CELL]));
    c_abort_hit: cover property ($rose(st.flag[dcs_pkg::DCS_F_ABORT]));
    c_addr_error: cover property (MEM.req && MEM_ERR);
    c_half_full: cover property ($rose(st.flag[dcs_pkg::DCS_F_HALF]));
endmodule

// >>> verification/dcs_mem_model.sv
// byte memory partner of the channel's memory master
// assumes requests stay up until answered; shares the channel clock
module dcs_mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // byte bus
    input wire dcs_pkg::dcs_mem_t mem,
    input wire logic slow,
    output logic ack,
    output logic err,
    output logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] store [0:255];
    logic [1:0] dly;
    always @(posedge clk) begin
        ack <= 1'b0;
        err <= 1'b0;
        // read data wander between answers
        rdata <= rdata + 8'h3B;
        if (rst) begin
            dly <= 2'h0;
            rdata <= 8'h00;
            for (int i = 0; i < 256; i++) begin
                store[i] <= 8'(i) ^ 8'hA5;
            end
        end else if (!mem.req || ack || err) begin
            dly <= 2'h0;
        end else if (slow && dly != 2'h3) begin
            dly <= dly + 2'h1;
        end else if (mem.addr[31:24] == 8'hEE) begin
            // region with no memory behind it
            err <= 1'b1;
        end else begin
            ack <= 1'b1;
            if (mem.we) begin
                store[mem.addr[7:0]] <= mem.wdata;
            end else begin
                rdata <= store[mem.addr[7:0]];
            end
        end
    end
endmodule

// >>> verification/dcs_channel_tb_top.sv
// self-checking bench for the dma channel block
// assumes the channel design and the byte memory partner model
module dcs_channel_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic [4:0] AVS_ADDRESS = 5'h00;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST;
    dcs_pkg::dcs_mem_t MEM;
    logic MEM_ACK;
    logic MEM_ERR;
    logic [7:0] MEM_RDATA;
    logic IRQ_VALID = 1'b0;
    logic [7:0] IRQ_NUM = 8'h00;
    logic PAT_MATCH = 1'b0;
    logic IRQ;
    logic slow = 1'b1;
    int fails = 0;
    int tests_run = 0;
    always #25 CLK_SYS = ~CLK_SYS;
    dcs_channel u_dcs_channel (
        .CLK_SYS(CLK_SYS), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .MEM(MEM), .MEM_ACK(MEM_ACK), .MEM_ERR(MEM_ERR),
        .MEM_RDATA(MEM_RDATA), .IRQ_VALID(IRQ_VALID), .IRQ_NUM(IRQ_NUM),
        .PAT_MATCH(PAT_MATCH), .IRQ(IRQ));
    dcs_mem_model u_dcs_mem_model (
        .clk(CLK_SYS), .rst(RST), .mem(MEM), .slow(slow),
        .ack(MEM_ACK), .err(MEM_ERR), .rdata(MEM_RDATA));
    task automatic results();
        if (fails == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge CLK_SYS);
        AVS_ADDRESS <= a;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        AVS_WRITEDATA <= d;
        // hold the request until waitrequest is seen low at a rising edge
        do begin
            @(posedge CLK_SYS);
            n++;
            if (n > 20) begin
                fails++;
                results();
            end
        end while (AVS_WAITREQUEST !== 1'b0);
        q = AVS_READDATA;
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic wait_idle();
        logic [31:0] q;
        q = 32'hFFFF_FFFF;
        for (int n = 0; q[dcs_pkg::DCS_C_BUSY] !== 1'b0; n++) begin
            if (n > 400) begin
                fails++;
                results();
            end
            bus(1'b0, dcs_pkg::DCS_OFS_CTL, 32'h0, q);
        end
    endtask
    task automatic pulse(input logic pat, input logic [7:0] num);
        @(posedge CLK_SYS);
        PAT_MATCH <= pat;
        IRQ_VALID <= !pat;
        IRQ_NUM <= num;
        @(posedge CLK_SYS);
        PAT_MATCH <= 1'b0;
        IRQ_VALID <= 1'b0;
    endtask
    task automatic setup(input logic [31:0] s, input logic [31:0] d,
                         input logic [31:0] sz, input logic [31:0] dc,
                         input logic [31:0] ie);
        wr(dcs_pkg::DCS_OFS_SSA, s);
        wr(dcs_pkg::DCS_OFS_DSA, d);
        wr(dcs_pkg::DCS_OFS_SSIZ, sz);
        wr(dcs_pkg::DCS_OFS_DCSIZ, dc);
        wr(dcs_pkg::DCS_OFS_INT, ie);
    endtask
    task automatic t_reset();
        rd(dcs_pkg::DCS_OFS_INT, 32'h0000_0000);
        rd(dcs_pkg::DCS_OFS_SSA, 32'h0000_0000);
        rd(dcs_pkg::DCS_OFS_DSA, 32'h0000_0000);
        rd(dcs_pkg::DCS_OFS_SSIZ, 32'h0000_0000);
        rd(dcs_pkg::DCS_OFS_CTL, 32'h00FF_0000);
        chk({31'h0, IRQ}, 32'h0);
    endtask
    task automatic t_regs();
        wr(dcs_pkg::DCS_OFS_SSA, 32'hA5C3_0F1E);
        wr(dcs_pkg::DCS_OFS_DSA, 32'h5A3C_F0E1);
        wr(dcs_pkg::DCS_OFS_SSIZ, 32'hFFFF_1234);
        wr(5'h1C, 32'hFFFF_FFFF);
        rd(dcs_pkg::DCS_OFS_SSA, 32'hA5C3_0F1E);
        rd(dcs_pkg::DCS_OFS_DSA, 32'h5A3C_F0E1);
        rd(dcs_pkg::DCS_OFS_SSIZ, 32'h0000_1234);
        rd(5'h1C, 32'h0000_0000);
        rd(5'h02, 32'h0000_0000);
    endtask
    task automatic t_xfer();
        setup(32'h10, 32'h80, 32'h4, 32'h0002_0004, 32'h0004_0000);
        wr(dcs_pkg::DCS_OFS_CTL, 32'h00FF_0003);
        wait_idle();
        rd(dcs_pkg::DCS_OFS_INT, 32'h0004_0014);
        chk({31'h0, IRQ}, 32'h1);
        wr(dcs_pkg::DCS_OFS_INT, 32'h0000_0014);
        rd(dcs_pkg::DCS_OFS_INT, 32'h0000_0014);
        chk({31'h0, IRQ}, 32'h0);
        wr(dcs_pkg::DCS_OFS_INT, 32'h0004_0010);
        rd(dcs_pkg::DCS_OFS_INT, 32'h0004_0010);
        chk({31'h0, IRQ}, 32'h0);
        wr(dcs_pkg::DCS_OFS_CTL, 32'h00FF_0003);
        wait_idle();
        rd(dcs_pkg::DCS_OFS_INT, 32'h0004_001C);
        rd(dcs_pkg::DCS_OFS_CTL, 32'h00FF_0000);
        for (int i = 0; i < 4; i++) begin
            chk({24'h0, u_dcs_mem_model.store[128 + i]},
                {24'h0, 8'(i + 16) ^ 8'hA5});
        end
    endtask
    task automatic t_abort();
        setup(32'h20, 32'h90, 32'h0, 32'h0002_0000, 32'h0000_0000);
        wr(dcs_pkg::DCS_OFS_CTL, 32'h0021_0003);
        pulse(1'b0, 8'h21);
        wait_idle();
        rd(dcs_pkg::DCS_OFS_INT, 32'h0000_0004);
        rd(dcs_pkg::DCS_OFS_CTL, 32'h0021_0001);
        wr(dcs_pkg::DCS_OFS_CTL, 32'h0021_000B);
        pulse(1'b0, 8'h20);
        pulse(1'b0, 8'h21);
        wait_idle();
        rd(dcs_pkg::DCS_OFS_INT, 32'h0000_0006);
        rd(dcs_pkg::DCS_OFS_CTL, 32'h0021_0008);
    endtask
    task automatic t_pattern();
        slow <= 1'b0;
        setup(32'h30, 32'hA0, 32'h0, 32'h0, 32'h0);
        wr(dcs_pkg::DCS_OFS_CTL, 32'h00FF_0023);
        pulse(1'b1, 8'h00);
        wait_idle();
        rd(dcs_pkg::DCS_OFS_INT, 32'h0000_0008);
        rd(dcs_pkg::DCS_OFS_CTL, 32'h00FF_0020);
    endtask
    task automatic t_aerr();
        setup(32'hEE00_0000, 32'hB0, 32'h4, 32'h4, 32'h0001_0000);
        wr(dcs_pkg::DCS_OFS_CTL, 32'h00FF_0003);
        wait_idle();
        rd(dcs_pkg::DCS_OFS_INT, 32'h0001_0001);
        rd(dcs_pkg::DCS_OFS_CTL, 32'h00FF_0000);
        chk({31'h0, IRQ}, 32'h1);
    endtask
    initial begin
        repeat (12) @(posedge CLK_SYS);
        RST <= 1'b0;
        t_reset();
        t_regs();
        t_xfer();
        t_abort();
        t_pattern();
        t_aerr();
        results();
    end
endmodule
